// >>> dv/sco_clock_ctrl_assertions.sv
`timescale 1ns/100ps
// ==========================================================
// Port checks for the secondary clock output control
module sco_clock_ctrl_assertions (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Clock outputs
   input wire logic secClkoutForceOff,
   input wire logic [4:0] secClockOut,
   input wire logic [4:0] secClockOutOe_n,
   // Reset pins
   input wire logic secondaryResetOut_n,
   input wire logic secClockStable,
   input wire logic secResetCtl,
   // Loader pins
   input wire logic maskShiftClockPinOut,
   input wire logic maskShiftClockPinOe_n,
   input wire logic maskLoadShiftPinOut,
   input wire logic maskLoadShiftPinOe_n,
   // Configuration access
   input wire logic cfgWrite,
   input wire logic cfgRead,
   input wire logic [7:0] cfgAddr,
   input wire logic [1:0] cfgByteEn,
   input wire logic [15:0] cfgWrData,
   input wire logic [15:0] cfgRdData,
   input wire logic cfgRdValid
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Force-off effects after the pin synchroniser
   chk_off_floats_out0:
      assert property (secClkoutForceOff [*4] |=> secClockOutOe_n[0])
      else $error("force-off left output 0 driven");
   chk_off_drives_low:
      assert property (secClkoutForceOff [*4]
         |=> (secClockOut[4:1] & ~secClockOutOe_n[4:1]) == 4'h0)
      else $error("force-off left a driven output high");
   // Mask bits steer the output enables two cycles after a write
   chk_pair_disable:
      assert property (cfgWrite && cfgAddr == 8'h68 && cfgByteEn == 2'h3 && secondaryResetOut_n
         |-> ##2 secClockOutOe_n[1] == &$past(cfgWrData[3:2], 2))
      else $error("output 1 enable does not follow its mask pair");
   chk_bit8_governs:
      assert property (cfgWrite && cfgAddr == 8'h68 && cfgByteEn[1] && secondaryResetOut_n
         |-> ##2 secClockOutOe_n[4] == $past(cfgWrData[8], 2))
      else $error("output 4 enable does not follow mask bit 8");
   // Loader pin protocol
   chk_load_then_shift:
      assert property ($fell(maskLoadShiftPinOe_n) && !secondaryResetOut_n
         |-> !maskLoadShiftPinOut [*4] ##1 maskLoadShiftPinOut)
      else $error("load pin not low one period then high");
   chk_shift_half_period:
      assert property (!secondaryResetOut_n && !maskShiftClockPinOe_n
         && $rose(maskShiftClockPinOut)
         |=> maskShiftClockPinOut || maskShiftClockPinOe_n)
      else $error("shift clock high phase too short");
   // Secondary reset release conditions
   chk_release_after_load:
      assert property ($rose(secondaryResetOut_n)
         |-> !$past(secResetCtl) && maskShiftClockPinOe_n && maskLoadShiftPinOe_n)
      else $error("secondary reset released early");
   chk_release_on_stable:
      assert property ($rose(secondaryResetOut_n) |-> $past(secClockStable, 3))
      else $error("secondary reset released while clock unstable");
   // Configuration read answers
   chk_read_answer:
      assert property (cfgRead && cfgAddr == 8'h68 |=> cfgRdValid)
      else $error("mask read not answered");
   chk_unmapped_zero:
      assert property (cfgRead && cfgAddr != 8'h68 |=> cfgRdValid && cfgRdData == 16'h0000)
      else $error("unmapped read not zero");
   chk_valid_pulse:
      assert property (cfgRdValid |-> $past(cfgRead))
      else $error("read valid without a read");
endmodule : sco_clock_ctrl_assertions

bind sco_clock_ctrl sco_clock_ctrl_assertions i_sco_clock_ctrl_assertions (.*);

// >>> dv/sco_shift_chain_model.sv
`timescale 1ns/100ps
// ==========================================================
// Two chained parallel-in serial-out shift registers on the board
module sco_shift_chain_model (
   // Pin levels
   input wire logic shiftClk,
   input wire logic loadShift,
   // Board options
   input wire logic present,
   input wire logic tieLevel,
   input wire logic [15:0] presence,
   // Serial data to the device
   output logic serialOut
);
   logic [15:0] chainQ;

   always @(posedge shiftClk) begin
      if (!loadShift) begin
         chainQ <= presence;
      end else begin
         chainQ <= {chainQ[14:0], ~chainQ[15]};
      end
   end

   assign serialOut = present ? chainQ[15] : tieLevel;
endmodule : sco_shift_chain_model

// >>> dv/testbench.sv
`timescale 1ns/100ps
// ==========================================================
// Self-checking bench for the secondary clock output control
module testbench;
   localparam int LIMIT = 20000;
   logic clk, rst_n, extOscSelect_n, primarySpeed66;
   logic primaryClockIn = 1'b0;
   logic extOscIn = 1'b0;
   logic secondarySpeed66, secClkoutForceOff, primaryResetIn_n, secClockStable;
   logic secResetCtl, maskSerialIn, maskShiftClockPinIn, maskLoadShiftPinIn;
   logic shiftPinCtlOut, shiftPinCtlOe_n, loadPinCtlOut, loadPinCtlOe_n, cfgWrite, cfgRead;
   logic secondaryResetOut_n, maskShiftClockPinOut, maskShiftClockPinOe_n;
   logic maskLoadShiftPinOut, maskLoadShiftPinOe_n, cfgRdValid, present, tieLevel, prev;
   logic [7:0] cfgAddr;
   logic [1:0] cfgByteEn, gpioPinIn;
   logic [15:0] cfgWrData, cfgRdData, presence, rd;
   logic [4:0] secClockOut, secClockOutOe_n;
   logic [15:0] pats [8] = '{16'h0003, 16'h0001, 16'h000c, 16'h0030, 16'h00c0, 16'h0100,
      16'hfe00, 16'h0102};
   int errors, comparisons, cycles, expMask, n, e;
   int priHalf = 8;
   int oscHalf = 5;

   // Pin levels with board pull-ups
   assign maskShiftClockPinIn = maskShiftClockPinOe_n ? 1'b1 : maskShiftClockPinOut;
   assign maskLoadShiftPinIn = maskLoadShiftPinOe_n ? 1'b1 : maskLoadShiftPinOut;

   sco_clock_ctrl i_sco_clock_ctrl (.*);
   sco_shift_chain_model i_sco_shift_chain_model (.shiftClk(maskShiftClockPinIn),
      .loadShift(maskLoadShiftPinIn), .present(present), .tieLevel(tieLevel),
      .presence(presence), .serialOut(maskSerialIn));

   // Main clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Slow source clocks and run timeout
   always @(negedge clk) begin
      cycles++;
      if (cycles % priHalf == 0) primaryClockIn <= ~primaryClockIn;
      if (cycles % oscHalf == 0) extOscIn <= ~extOscIn;
      if (cycles == LIMIT) begin
         errors++;
         end_of_test();
      end
   end

   // ==========================================================
   // Tasks
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   function automatic logic [4:0] expOe(input int m, input logic off);
      logic [4:0] r;
      for (int i = 0; i < 4; i++) r[i] = m[2*i] & m[2*i+1];
      r[4] = m[8];
      r[0] = r[0] | off;
      return r;
   endfunction : expOe

   task automatic checkOuts(input string what);
      logic [4:0] x;
      x = expOe(expMask, secClkoutForceOff);
      check(what, {11'h0, secClockOutOe_n}, {11'h0, x});
      check(what, {12'h0, secClockOut[4:1] & ~x[4:1] & {4{secClkoutForceOff}}}, 16'h0000);
   endtask : checkOuts

   task automatic cfgWr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
      @(negedge clk);
      {cfgWrite, cfgAddr, cfgByteEn, cfgWrData} = {1'b1, a, be, d};
      @(negedge clk);
      cfgWrite = 1'b0;
      if (a == 8'h68 && be[0]) expMask[7:0] = d[7:0];
      if (a == 8'h68 && be[1]) expMask[15:8] = d[15:8];
      repeat (3) @(negedge clk);
   endtask : cfgWr

   task automatic cfgRd(input logic [7:0] a, output logic [15:0] d);
      @(negedge clk);
      {cfgRead, cfgAddr} = {1'b1, a};
      @(negedge clk);
      cfgRead = 1'b0;
      check("read valid", {15'h0, cfgRdValid}, 16'h0001);
      d = cfgRdData;
   endtask : cfgRd

   task automatic waitPin(input logic v);
      int k;
      k = 0;
      while (maskLoadShiftPinOe_n !== v && k < 200) begin
         @(negedge clk);
         k++;
      end
      check("loader pins", {15'h0, maskLoadShiftPinOe_n}, {15'h0, v});
   endtask : waitPin

   task automatic loadSeq(input logic abort);
      {rst_n, primaryResetIn_n, secClockStable, secResetCtl} = 4'b0001;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      primaryResetIn_n = 1'b1;
      if (abort) begin
         repeat (30) @(negedge clk);
         primaryResetIn_n = 1'b0;
         presence = ~presence;
         repeat (4) @(negedge clk);
         primaryResetIn_n = 1'b1;
      end
      waitPin(1'b0);
      waitPin(1'b1);
      expMask = present ? presence : {16{tieLevel}};
      repeat (6) @(negedge clk);
      check("reset held", {15'h0, secondaryResetOut_n}, 16'h0000);
      secClockStable = 1'b1;
      repeat (6) @(negedge clk);
      check("reset ctl", {15'h0, secondaryResetOut_n}, 16'h0000);
      secResetCtl = 1'b0;
      repeat (2) @(negedge clk);
      check("reset free", {15'h0, secondaryResetOut_n}, 16'h0001);
      tieLevel = ~tieLevel;
      presence = ~presence;
      {loadPinCtlOut, shiftPinCtlOut, shiftPinCtlOe_n, loadPinCtlOe_n} = {2'($urandom), 2'b00};
      repeat (4) @(negedge clk);
      check("gpio pins", {14'h0, gpioPinIn}, {14'h0, loadPinCtlOut, shiftPinCtlOut});
      {shiftPinCtlOe_n, loadPinCtlOe_n} = 2'b11;
      cfgRd(8'h68, rd);
      check("loaded mask", rd, expMask[15:0]);
      checkOuts("load outputs");
   endtask : loadSeq

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test

   // ==========================================================
   // Test sequence
   initial begin
      {rst_n, primarySpeed66, secondarySpeed66} = '0;
      {secClkoutForceOff, primaryResetIn_n, secClockStable, cfgWrite, cfgRead} = '0;
      {shiftPinCtlOut, loadPinCtlOut, tieLevel, cfgAddr, cfgByteEn, cfgWrData} = '0;
      {extOscSelect_n, secResetCtl, shiftPinCtlOe_n, loadPinCtlOe_n, present} = '1;
      presence = 16'($urandom(32'h6a4d));
      loadSeq(1'b0);
      presence = 16'($urandom);
      loadSeq(1'b1);
      $display("Test chain load done");
      {present, tieLevel} = 2'b00;
      loadSeq(1'b0);
      tieLevel = 1'b1;
      loadSeq(1'b0);
      $display("Test tied serial done");
      for (int i = 0; i < 9; i++) begin
         cfgWr(8'h68, (i == 8) ? 2'h1 : 2'h3, (i == 8) ? 16'($urandom) : pats[i % 8]);
         cfgRd(8'h68, rd);
         check("written mask", rd, expMask[15:0]);
         for (int f = 0; f < 2; f++) begin
            secClkoutForceOff = f[0];
            repeat (6) @(negedge clk);
            checkOuts("mask outputs");
         end
      end
      cfgWr(8'h40, 2'h3, 16'hffff);
      cfgRd(8'h40, rd);
      check("unmapped read", rd, 16'h0000);
      cfgRd(8'h68, rd);
      check("mask kept", rd, expMask[15:0]);
      $display("Test configuration done");
      secClkoutForceOff = 1'b0;
      cfgWr(8'h68, 2'h3, 16'h0000);
      for (int s = 0; s < 8; s++) begin
         {extOscSelect_n, primarySpeed66, secondarySpeed66} = 3'(s);
         repeat (20) @(negedge clk);
         n = 0;
         prev = secClockOut[1];
         repeat (480) begin
            @(negedge clk);
            if (secClockOut[1] && !prev) n++;
            prev = secClockOut[1];
         end
         e = 480 / (2 * (s[2] ? priHalf : oscHalf) * ((s[1:0] == 2) ? 2 : 1));
         check("clock edges", {15'h0, n >= e - 1 && n <= e + 1}, 16'h0001);
      end
      $display("Test clock source done");
      end_of_test();
   end
endmodule : testbench

// >>> hw/sco_clk_gen.sv
`timescale 1ns/100ps
// ==========================================================
// Source select and fixed divider for the secondary clocks
module sco_clk_gen (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Synchronised sources and straps
   input wire logic primaryClockIn,
   input wire logic extOscIn,
   input wire logic extOscSelect_n,
   input wire logic primarySpeed66,
   input wire logic secondarySpeed66,
   // Generated source clock
   output logic srcClk
);

   typedef struct packed {
      logic prevSel;
      logic divClk;
      logic outClk;
   } sco_clk_state_t;

   sco_clk_state_t state_q;
   sco_clk_state_t state_d;
   logic selClk;
   logic divide;

   assign selClk = extOscSelect_n ? primaryClockIn : extOscIn;
   assign divide = primarySpeed66 && !secondarySpeed66;

   // Toggle on every source rising edge, selected only when dividing
   always_comb begin
      state_d = state_q;
      state_d.prevSel = selClk;
      if (selClk && !state_q.prevSel) begin
         state_d.divClk = !state_q.divClk;
      end
      state_d.outClk = divide ? state_d.divClk : selClk;
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign srcClk = state_q.outClk;

endmodule : sco_clk_gen

// >>> hw/sco_clock_ctrl.sv
`timescale 1ns/100ps
// ==========================================================
// Secondary clock output control
//
// Overview of operation
// - Force-off high: output 0 floats, outputs 4..1 driven low.
// - A masked output stays disabled regardless of force-off.
// - Primary reset released during secondary reset starts 16-bit serial mask load.
// - Secondary reset held asserted until the mask load has finished.
// - Shift clock pin clocks external registers, never above 66 MHz.
// - Load/shift pin low one cycle to load, then high to shift.
// - Serial mask arrives MSB first, LSB last.
// - After shifting, both pins float; reset released only if reset bit clear.
// - After loading, serial input ignored; pins return to GPIO control.
// - Mask register stays writable by configuration writes after reset.
// - Bit pairs 1:0..7:6 govern outputs 0..3, bit 8 output 4.
// - Outputs 0..3 enabled unless both bits of their pair are one.
// - Bit 8 zero enables output 4, one disables it.
// - Serial input held low enables all outputs, high floats all.
// - Secondary reset not released while clock-stable input is low.
// - Outputs come from primary clock, or oscillator when select low.
// - Divide by two only for primary speed 1, secondary speed 0.
// - Outputs derivable from primary clock, oscillator, or half of either.
module sco_clock_ctrl (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Clock sources and straps
   input wire logic primaryClockIn,
   input wire logic extOscIn,
   input wire logic extOscSelect_n,
   input wire logic primarySpeed66,
   input wire logic secondarySpeed66,
   // Secondary clock outputs
   input wire logic secClkoutForceOff,
   output logic [4:0] secClockOut,
   output logic [4:0] secClockOutOe_n,
   // Reset pins
   input wire logic primaryResetIn_n,
   output logic secondaryResetOut_n,
   input wire logic secClockStable,
   input wire logic secResetCtl,
   // Serial mask pins
   input wire logic maskSerialIn,
   input wire logic maskShiftClockPinIn,
   output logic maskShiftClockPinOut,
   output logic maskShiftClockPinOe_n,
   input wire logic maskLoadShiftPinIn,
   output logic maskLoadShiftPinOut,
   output logic maskLoadShiftPinOe_n,
   // GPIO control takeover
   input wire logic shiftPinCtlOut,
   input wire logic shiftPinCtlOe_n,
   input wire logic loadPinCtlOut,
   input wire logic loadPinCtlOe_n,
   output logic [1:0] gpioPinIn,
   // Configuration access
   input wire logic cfgWrite,
   input wire logic cfgRead,
   input wire logic [7:0] cfgAddr,
   input wire logic [1:0] cfgByteEn,
   input wire logic [15:0] cfgWrData,
   output logic [15:0] cfgRdData,
   output logic cfgRdValid
);

   // ==========================================================
   // Types and state
   typedef struct packed {
      sco_pkg::sco_load_state_t loadState;
      logic [sco_pkg::SHIFT_PHASE_W-1:0] phase;
      logic [sco_pkg::MASK_CNT_W-1:0] bitCnt;
      logic [15:0] shiftReg;
      logic [15:0] clockOutputMaskReg;
      logic shiftClk;
      logic loadShift;
      logic pinsOwned;
      logic secResetOut_n;
      logic [4:0] clkOut;
      logic [4:0] clkOe_n;
      logic [15:0] rdData;
      logic rdValid;
   } sco_state_t;

   localparam logic [sco_pkg::SHIFT_PHASE_W-1:0] PHASE_LAST =
      sco_pkg::SHIFT_PHASE_W'(2 * sco_pkg::SHIFT_HALF_CYC - 1);
   localparam logic [sco_pkg::SHIFT_PHASE_W-1:0] PHASE_HALF =
      sco_pkg::SHIFT_PHASE_W'(sco_pkg::SHIFT_HALF_CYC);
   localparam logic [sco_pkg::SHIFT_PHASE_W-1:0] PHASE_SAMPLE =
      sco_pkg::SHIFT_PHASE_W'(sco_pkg::SHIFT_HALF_CYC - 1);
   localparam logic [sco_pkg::MASK_CNT_W-1:0] BITS_LAST =
      sco_pkg::MASK_CNT_W'(sco_pkg::MASK_BITS - 1);

   sco_state_t state_q;
   sco_state_t state_d;
   logic [sco_pkg::SYN_W-1:0] pinRaw;
   logic [sco_pkg::SYN_W-1:0] pinSync;
   logic srcClk;
   logic [4:0] maskEnable;
   logic hitMask;

   // ==========================================================
   // Mask decode
   function automatic logic [4:0] mask_to_enable(input logic [15:0] mask);
      logic [4:0] en;
      en = '0;
      for (int i = 0; i < 4; i++) begin
         en[i] = !(mask[2*i] && mask[2*i+1]);
      end
      en[4] = !mask[sco_pkg::MASK_OUT4_BIT];
      return en;
   endfunction : mask_to_enable

   // Byte lane merge for configuration writes
   function automatic logic [15:0] merge_bytes(
      input logic [15:0] oldVal,
      input logic [15:0] newVal,
      input logic [1:0] be
   );
      logic [15:0] res;
      res = oldVal;
      if (be[0]) begin
         res[7:0] = newVal[7:0];
      end
      if (be[1]) begin
         res[15:8] = newVal[15:8];
      end
      return res;
   endfunction : merge_bytes

   // ==========================================================
   // Pin synchronisers
   assign pinRaw = {maskLoadShiftPinIn, maskShiftClockPinIn, maskSerialIn, secClockStable,
                    primaryResetIn_n, secClkoutForceOff, secondarySpeed66, primarySpeed66,
                    extOscSelect_n, extOscIn, primaryClockIn};

   sco_sync #(
      .WIDTH(sco_pkg::SYN_W)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .asyncIn(pinRaw),
      .syncOut(pinSync)
   );

   // ==========================================================
   // Source clock generation
   sco_clk_gen u_clk_gen (
      .clk(clk),
      .rst_n(rst_n),
      .primaryClockIn(pinSync[sco_pkg::SYN_PRI_CLK]),
      .extOscIn(pinSync[sco_pkg::SYN_OSC_CLK]),
      .extOscSelect_n(pinSync[sco_pkg::SYN_OSC_SEL_N]),
      .primarySpeed66(pinSync[sco_pkg::SYN_PRI_66]),
      .secondarySpeed66(pinSync[sco_pkg::SYN_SEC_66]),
      .srcClk(srcClk)
   );

   // ==========================================================
   // Output enables from the stored mask
   // pair and bit mapping
   assign maskEnable = mask_to_enable(state_q.clockOutputMaskReg);
   assign hitMask = (cfgAddr == sco_pkg::MASK_REG_OFFSET);

   // ==========================================================
   // Next state
   always_comb begin
      state_d = state_q;
      state_d.rdValid = 1'b0;

      // Loader sequencing
      unique case (state_q.loadState)
         sco_pkg::SCO_IDLE: begin
            state_d.secResetOut_n = 1'b0;
            state_d.pinsOwned = 1'b0;
            if (pinSync[sco_pkg::SYN_PRI_RST_N]) begin
               state_d.loadState = sco_pkg::SCO_LOAD;
               state_d.pinsOwned = 1'b1;
               state_d.loadShift = 1'b0;
               state_d.shiftClk = 1'b0;
               state_d.phase = '0;
               state_d.bitCnt = '0;
            end
         end
         sco_pkg::SCO_LOAD: begin
            state_d.loadShift = 1'b0;
            state_d.phase = state_q.phase + 1'b1;
            state_d.shiftClk = (state_d.phase >= PHASE_HALF);
            if (state_q.phase == PHASE_LAST) begin
               state_d.phase = '0;
               state_d.shiftClk = 1'b0;
               state_d.loadShift = 1'b1;
               state_d.loadState = sco_pkg::SCO_SHIFT;
            end
         end
         sco_pkg::SCO_SHIFT: begin
            state_d.loadShift = 1'b1;
            state_d.phase = state_q.phase + 1'b1;
            state_d.shiftClk = (state_d.phase >= PHASE_HALF);
            if (state_q.phase == PHASE_LAST) begin
               state_d.phase = '0;
               state_d.shiftClk = 1'b0;
            end
            if (state_q.phase == PHASE_SAMPLE) begin
               state_d.shiftReg = {state_q.shiftReg[14:0], pinSync[sco_pkg::SYN_SERIAL]};
               state_d.bitCnt = state_q.bitCnt + 1'b1;
               if (state_q.bitCnt == BITS_LAST) begin
                  state_d.clockOutputMaskReg = state_d.shiftReg;
                  state_d.pinsOwned = 1'b0;
                  state_d.shiftClk = 1'b0;
                  state_d.loadState = sco_pkg::SCO_DONE;
               end
            end
         end
         sco_pkg::SCO_DONE: begin
            state_d.pinsOwned = 1'b0;
            state_d.secResetOut_n = pinSync[sco_pkg::SYN_CLK_STABLE] && !secResetCtl;
         end
      endcase

      // new reset sequence restarts the loader
      if (!pinSync[sco_pkg::SYN_PRI_RST_N]) begin
         state_d.loadState = sco_pkg::SCO_IDLE;
         state_d.secResetOut_n = 1'b0;
         state_d.pinsOwned = 1'b0;
         state_d.shiftClk = 1'b0;
      end

      if (cfgWrite && hitMask && (state_q.loadState == sco_pkg::SCO_DONE)) begin
         state_d.clockOutputMaskReg = merge_bytes(state_q.clockOutputMaskReg, cfgWrData,
                                                  cfgByteEn);
      end

      // Configuration reads, unmapped reads return zero
      if (cfgRead) begin
         state_d.rdValid = 1'b1;
         state_d.rdData = hitMask ? state_q.clockOutputMaskReg : 16'h0000;
      end

      // Output drive per clock
      for (int i = 0; i < sco_pkg::NUM_CLK_OUT; i++) begin
         if (!maskEnable[i]) begin
            state_d.clkOut[i] = 1'b0;
            state_d.clkOe_n[i] = 1'b1;
         end else if (pinSync[sco_pkg::SYN_FORCE_OFF]) begin
            state_d.clkOut[i] = 1'b0;
            state_d.clkOe_n[i] = (i == 0);
         end else begin
            state_d.clkOut[i] = srcClk;
            state_d.clkOe_n[i] = 1'b0;
         end
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q.loadState <= sco_pkg::SCO_IDLE;
         state_q.phase <= '0;
         state_q.bitCnt <= '0;
         state_q.shiftReg <= 16'h0000;
         state_q.clockOutputMaskReg <= sco_pkg::MASK_RESET;
         state_q.shiftClk <= 1'b0;
         state_q.loadShift <= 1'b0;
         state_q.pinsOwned <= 1'b0;
         state_q.secResetOut_n <= 1'b0;
         state_q.clkOut <= 5'h00;
         state_q.clkOe_n <= 5'h1f;
         state_q.rdData <= 16'h0000;
         state_q.rdValid <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   // ==========================================================
   // Pin outputs
   // pins revert to GPIO control
   assign maskShiftClockPinOut = state_q.pinsOwned ? state_q.shiftClk : shiftPinCtlOut;
   assign maskShiftClockPinOe_n = state_q.pinsOwned ? 1'b0 : shiftPinCtlOe_n;
   assign maskLoadShiftPinOut = state_q.pinsOwned ? state_q.loadShift : loadPinCtlOut;
   assign maskLoadShiftPinOe_n = state_q.pinsOwned ? 1'b0 : loadPinCtlOe_n;
   assign gpioPinIn = {pinSync[sco_pkg::SYN_LOAD_PIN], pinSync[sco_pkg::SYN_SHIFT_PIN]};

   // Registered outputs
   assign secClockOut = state_q.clkOut;
   assign secClockOutOe_n = state_q.clkOe_n;
   assign secondaryResetOut_n = state_q.secResetOut_n;
   assign cfgRdData = state_q.rdData;
   assign cfgRdValid = state_q.rdValid;

endmodule : sco_clock_ctrl

// >>> hw/sco_pkg.sv
// ==========================================================
// Shared constants for the secondary clock output control
package sco_pkg;

   // ==========================================================
   // Clocking
   localparam int CLK_FREQ_HZ = 50000000;
   // Fastest rate allowed on the shift clock pin
   localparam int SHIFT_CLK_MAX_HZ = 66000000;
   // Half period in cycles that the rate limit alone asks for, rounded up
   localparam int SHIFT_HALF_RATE_CYC = (CLK_FREQ_HZ + 2 * SHIFT_CLK_MAX_HZ - 1) /
                                        (2 * SHIFT_CLK_MAX_HZ);
   // Two cycles of synchroniser latency on the serial input need covering
   localparam int SHIFT_HALF_SYNC_CYC = 2;
   localparam int SHIFT_HALF_CYC = (SHIFT_HALF_RATE_CYC > SHIFT_HALF_SYNC_CYC) ?
                                   SHIFT_HALF_RATE_CYC : SHIFT_HALF_SYNC_CYC;
   localparam int SHIFT_PHASE_W = 4;

   // ==========================================================
   // Mask register
   localparam int MASK_W = 16;
   localparam int MASK_BITS = 16;
   localparam int MASK_CNT_W = 5;
   localparam logic [7:0] MASK_REG_OFFSET = 8'h68;
   localparam logic [15:0] MASK_RESET = 16'h0000;
   localparam int MASK_OUT4_BIT = 8;
   localparam int NUM_CLK_OUT = 5;

   // ==========================================================
   // Pin synchroniser lane positions
   localparam int SYN_PRI_CLK = 0;
   localparam int SYN_OSC_CLK = 1;
   localparam int SYN_OSC_SEL_N = 2;
   localparam int SYN_PRI_66 = 3;
   localparam int SYN_SEC_66 = 4;
   localparam int SYN_FORCE_OFF = 5;
   localparam int SYN_PRI_RST_N = 6;
   localparam int SYN_CLK_STABLE = 7;
   localparam int SYN_SERIAL = 8;
   localparam int SYN_SHIFT_PIN = 9;
   localparam int SYN_LOAD_PIN = 10;
   localparam int SYN_W = 11;

   // ==========================================================
   // Mask loader states, Gray along the path
   typedef enum logic [1:0] {
      SCO_IDLE  = 2'b00,
      SCO_LOAD  = 2'b01,
      SCO_SHIFT = 2'b11,
      SCO_DONE  = 2'b10
   } sco_load_state_t;

endpackage : sco_pkg

// >>> hw/sco_sync.sv
`timescale 1ns/100ps
// ==========================================================
// Two-stage synchroniser for a group of pin inputs
module sco_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Asynchronous inputs
   input wire logic [WIDTH-1:0] asyncIn,
   // Synchronised outputs
   output logic [WIDTH-1:0] syncOut
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } sco_sync_state_t;

   sco_sync_state_t state_q;
   sco_sync_state_t state_d;

   // Stage two reads only stage one
   always_comb begin
      state_d = state_q;
      state_d.stage1 = asyncIn;
      state_d.stage2 = state_q.stage1;
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign syncOut = state_q.stage2;

endmodule : sco_sync
